// ### tgw_pkg.sv
//==============================================================
// Purpose: Shared constants and types for the timer group block
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Counts are in prescaled ticks or core clock cycles
package tgw_pkg;
	localparam int TGW_CNT_W    = 54;
	localparam int TGW_DIV_W    = 16;
	localparam int TGW_WDT_W    = 32;
	localparam int TGW_STAGES   = 4;
	localparam int TGW_NUM_GRP  = 2;
	// Counter value after reset
	localparam logic [53:0] TGW_CNT_RST = 54'h0;
	// Boot guard default, in core clock cycles
	localparam logic [31:0] TGW_BOOT_TMO = 32'h0098_9680;
	// Unlock key for the watchdog configuration
	localparam logic [31:0] TGW_WDT_KEY = 32'h50D8_3AA1;

	// Stage action encoding
	typedef enum logic [1:0] {
		TGW_ACT_OFF  = 2'b00,
		TGW_ACT_INT  = 2'b01,
		TGW_ACT_CPU  = 2'b10,
		TGW_ACT_CORE = 2'b11
	} tgw_act_t;

	// Watchdog sequencing state
	typedef enum logic [1:0] {
		TGW_WS_IDLE = 2'b00,
		TGW_WS_RUN  = 2'b01,
		TGW_WS_DONE = 2'b10
	} tgw_wstate_t;
endpackage

// ### tgw_wdt_if.sv
//==============================================================
// Purpose: Carries watchdog configuration into the watchdog core
// Assumes: Fields are registered in the top before use
// Notes:   One modport per side
`timescale 1ns/1ps
interface tgw_wdt_if;
	logic                enable;    // Watchdog run
	logic                feed;      // Restart pulse
	logic [3:0]          stage_en;  // Per-stage enable
	logic [4*32-1:0]     tmo;       // Per-stage timeouts
	logic [4*2-1:0]      act;       // Per-stage actions
	logic                intr;      // Interrupt action pulse
	logic                cpu_rst;   // Processor reset pulse
	logic                core_rst;  // Core reset pulse
	modport top (output enable, feed, stage_en, tmo, act,
		input intr, cpu_rst, core_rst);
	modport core (input enable, feed, stage_en, tmo, act,
		output intr, cpu_rst, core_rst);
endinterface

// ### tgw_wdt_core.sv
//==============================================================
// Purpose: Four-stage main system watchdog sequencer
// Assumes: Configuration already qualified by write protection
// Notes:   Action outputs are one-cycle registered pulses
`timescale 1ns/1ps
module tgw_wdt_core (
	input  wire logic core_clk,  // Core clock
	input  wire logic rst,       // Sync reset
	tgw_wdt_if.core   wif        // Configuration and actions
);
	import tgw_pkg::*;

	tgw_wstate_t       st_q, st_d;
	logic [1:0]        stg_q, stg_d;
	logic [31:0]       cnt_q, cnt_d;
	logic              intr_q, intr_d, cpu_q, cpu_d, core_q, core_d;
	logic [31:0]       tmo_cur;
	tgw_act_t          act_cur;

	assign tmo_cur = wif.tmo[stg_q*32 +: 32];
	assign act_cur = tgw_act_t'(wif.act[stg_q*2 +: 2]);

	// Next state of the stage sequencer
	always_comb
	begin
		st_d   = st_q;
		stg_d  = stg_q;
		cnt_d  = cnt_q;
		intr_d = 1'b0;
		cpu_d  = 1'b0;
		core_d = 1'b0;
		unique case (st_q)
			TGW_WS_IDLE:
			begin
				stg_d = 2'd0;
				cnt_d = 32'h0;
				if (wif.enable)
					st_d = TGW_WS_RUN;
			end
			TGW_WS_RUN:
			begin
				if (!wif.enable)
					st_d = TGW_WS_IDLE;
				else if (wif.feed)
				begin
					stg_d = 2'd0;
					cnt_d = 32'h0;
				end
				else if (!wif.stage_en[stg_q]
					|| act_cur == TGW_ACT_OFF)
				begin
					cnt_d = 32'h0;
					if (stg_q == 2'd3)
						st_d = TGW_WS_DONE;
					else
						stg_d = stg_q + 2'd1;
				end
				else if (cnt_q >= tmo_cur)
				begin
					cnt_d  = 32'h0;
					intr_d = (act_cur == TGW_ACT_INT);
					cpu_d  = (act_cur == TGW_ACT_CPU);
					core_d = (act_cur == TGW_ACT_CORE);
					if (stg_q == 2'd3)
						st_d = TGW_WS_DONE;
					else
						stg_d = stg_q + 2'd1;
				end
				else
					cnt_d = cnt_q + 32'h1;
			end
			TGW_WS_DONE:
			begin
				if (!wif.enable || wif.feed)
					st_d = TGW_WS_IDLE;
			end
			default:
				st_d = TGW_WS_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_q   <= TGW_WS_IDLE;
			stg_q  <= 2'd0;
			cnt_q  <= 32'h0;
			intr_q <= 1'b0;
			cpu_q  <= 1'b0;
			core_q <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			stg_q  <= stg_d;
			cnt_q  <= cnt_d;
			intr_q <= intr_d;
			cpu_q  <= cpu_d;
			core_q <= core_d;
		end
	end

	assign wif.intr     = intr_q;
	assign wif.cpu_rst  = cpu_q;
	assign wif.core_rst = core_q;

	// Feeding restarts stage zero with a cleared count
	feed_restart_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(st_q == TGW_WS_RUN && wif.enable && wif.feed)
		|=> (stg_q == 2'd0 && cnt_q == 32'h0))
		else $error("feed did not restart watchdog");
	// A CPU reset stage action gives a processor reset pulse
	stage_action_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(st_q == TGW_WS_RUN && wif.enable && !wif.feed
		&& wif.stage_en[stg_q] && act_cur == TGW_ACT_CPU
		&& cnt_q >= tmo_cur) |=> cpu_q)
		else $error("cpu reset action missing");
	// Disabled stage never fires
	stage_skip_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(st_q == TGW_WS_RUN && !wif.stage_en[stg_q])
		|=> !(intr_q || cpu_q || core_q))
		else $error("disabled stage fired");
	cover_fire: cover property (@(posedge core_clk) intr_q);
	cover_done: cover property (@(posedge core_clk) st_q == TGW_WS_DONE);
endmodule // tgw_wdt_core

// ### tgw_top.sv
//==============================================================
// Purpose: Timer group with one general timer and one watchdog
// Assumes: Control bits arrive as plain ports, synchronous
// Notes:   Each group instance holds one timer and one watchdog
//==============================================================
`timescale 1ns/1ps
module tgw_top #(
	parameter int          GROUP_ID = 0,              // Group index
	parameter logic [31:0] BOOT_TMO = tgw_pkg::TGW_BOOT_TMO // Boot guard
) (
	input  wire logic                         core_clk,    // Core clock
	input  wire logic                         rst,         // Sync reset
	input  wire logic                         tmr_en,      // Run, 0 halts
	input  wire logic                         tmr_up,      // Count up
	input  wire logic                         tmr_reload_en, // Auto reload
	input  wire logic [tgw_pkg::TGW_DIV_W-1:0] tmr_div,    // Ratio-1
	input  wire logic [tgw_pkg::TGW_CNT_W-1:0] tmr_reload, // Reload value
	input  wire logic                         tmr_load,    // Load pulse
	input  wire logic [tgw_pkg::TGW_CNT_W-1:0] tmr_alarm,  // Alarm value
	input  wire logic                         tmr_alarm_en, // Alarm enable
	input  wire logic                         tmr_int_clr, // Clear pulse
	output logic [tgw_pkg::TGW_CNT_W-1:0]      tmr_count,   // Live count
	output logic                              tmr_int,     // Alarm level
	input  wire logic [31:0]                  wdt_key,     // Key value
	input  wire logic                         wdt_key_wr,  // Key strobe
	input  wire logic                         wdt_cfg_wr,  // Config strobe
	input  wire logic                         wdt_en_in,   // Enable
	input  wire logic [3:0]                   wdt_stage_en, // Stage enables
	input  wire logic [4*32-1:0]              wdt_tmo,     // Timeouts
	input  wire logic [4*2-1:0]               wdt_act,     // Actions
	input  wire logic                         wdt_feed,    // Feed pulse
	input  wire logic                         boot_done,   // Boot finished
	output logic                              wdt_locked,  // Protected
	output logic                              wdt_int,     // Stage interrupt
	output logic                              cpu_rst_out, // Processor reset
	output logic                              core_rst_out, // Core reset
	output logic                              sys_rst_out  // System reset
);
	import tgw_pkg::*;

	//==========================================================
	// General timer
	logic [TGW_DIV_W-1:0] pre_q, pre_d;
	logic [TGW_CNT_W-1:0] cnt_q, cnt_d;
	logic                 int_q, int_d;
	logic                 tick, hit;

	// Tick at or past the ratio, so a lowered ratio cannot stall
	assign tick = tmr_en && (pre_q >= tmr_div);
	assign hit  = tmr_alarm_en && (cnt_q == tmr_alarm);

	// Prescaler, counter and alarm next values
	always_comb
	begin
		pre_d = pre_q;
		cnt_d = cnt_q;
		int_d = int_q;
		if (tmr_en)
			pre_d = tick ? '0 : pre_q + 16'h1;
		if (tmr_load)
			cnt_d = tmr_reload;
		else if (hit && tmr_reload_en)
			cnt_d = tmr_reload;
		else if (tick)
			cnt_d = tmr_up ? cnt_q + 54'h1 : cnt_q - 54'h1;
		if (tmr_int_clr)
			int_d = 1'b0;
		if (hit)
			int_d = 1'b1;
	end

	// Timer registers; halt stops ticks, load and alarm reload still act
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pre_q <= '0;
			cnt_q <= TGW_CNT_RST;
			int_q <= 1'b0;
		end
		else
		begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			int_q <= int_d;
		end
	end

	assign tmr_count = cnt_q;
	assign tmr_int   = int_q;

	//==========================================================
	// Watchdog protection and configuration
	tgw_wdt_if wif ();
	logic            lock_q, lock_d;
	logic            en_q, en_d, feed_q, feed_d;
	logic [3:0]      sen_q, sen_d;
	logic [127:0]    tmo_q, tmo_d;
	logic [7:0]      act_q, act_d;
	logic            boot_q, boot_d;
	logic [31:0]     bcnt_q, bcnt_d;
	logic            sys_q, sys_d;
	logic            cpu_q, core_q, wint_q;

	// Lock, config and boot guard next values
	always_comb
	begin
		lock_d = lock_q;
		en_d   = en_q;
		sen_d  = sen_q;
		tmo_d  = tmo_q;
		act_d  = act_q;
		feed_d = wdt_feed && !lock_q;
		boot_d = boot_q;
		bcnt_d = bcnt_q;
		sys_d  = 1'b0;
		if (wdt_key_wr)
			lock_d = (wdt_key != TGW_WDT_KEY);
		if (wdt_cfg_wr && !lock_q)
		begin
			en_d  = wdt_en_in;
			sen_d = wdt_stage_en;
			tmo_d = wdt_tmo;
			act_d = wdt_act;
		end
		if (boot_q)
		begin
			if (boot_done)
				boot_d = 1'b0;
			else if (bcnt_q >= BOOT_TMO)
			begin
				sys_d  = 1'b1;
				boot_d = 1'b0;
			end
			else
				bcnt_d = bcnt_q + 32'h1;
		end
	end

	// Protection and boot registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			lock_q <= 1'b1;
			en_q   <= (GROUP_ID == 0);
			sen_q  <= 4'hF;
			tmo_q  <= {4{BOOT_TMO}};
			act_q  <= {4{TGW_ACT_CORE}};
			feed_q <= 1'b0;
			boot_q <= (GROUP_ID == 0);
			bcnt_q <= 32'h0;
			sys_q  <= 1'b0;
			cpu_q  <= 1'b0;
			core_q <= 1'b0;
			wint_q <= 1'b0;
		end
		else
		begin
			lock_q <= lock_d;
			en_q   <= en_d;
			sen_q  <= sen_d;
			tmo_q  <= tmo_d;
			act_q  <= act_d;
			feed_q <= feed_d;
			boot_q <= boot_d;
			bcnt_q <= bcnt_d;
			sys_q  <= sys_d;
			cpu_q  <= wif.cpu_rst;
			core_q <= wif.core_rst;
			wint_q <= wif.intr;
		end
	end

	assign wif.enable   = en_q;
	assign wif.feed     = feed_q;
	assign wif.stage_en = sen_q;
	assign wif.tmo      = tmo_q;
	assign wif.act      = act_q;

	// One watchdog per group, beside the timer
	tgw_wdt_core u_wdt (
		.core_clk (core_clk),
		.rst      (rst),
		.wif      (wif.core)
	);

	assign wdt_locked   = lock_q;
	assign wdt_int      = wint_q;
	assign cpu_rst_out  = cpu_q;
	assign core_rst_out = core_q;
	assign sys_rst_out  = sys_q;

	//==========================================================
	// Checks
	// No count change between prescaled ticks
	prescale_hold_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(tmr_en && pre_q < tmr_div && !tmr_load && !hit)
		|=> $stable(cnt_q))
		else $error("counter moved between ticks");
	// Up count adds one per tick
	count_dir_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(tick && tmr_up && !tmr_load && !hit)
		|=> cnt_q == $past(cnt_q) + 54'h1)
		else $error("up count wrong");
	// Down count takes one per tick
	count_down_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(tick && !tmr_up && !tmr_load && !hit)
		|=> cnt_q == $past(cnt_q) - 54'h1)
		else $error("down count wrong");
	// Alarm with reload takes the reload value
	auto_reload_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(hit && tmr_reload_en && !tmr_load)
		|=> cnt_q == $past(tmr_reload))
		else $error("reload missed");
	// Load pulse shows the reload value
	load_value_a: assert property (
		@(posedge core_clk) disable iff (rst)
		tmr_load |=> tmr_count == $past(tmr_reload))
		else $error("load value wrong");
	// A tick shows up on the live output
	live_value_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(tick && !tmr_load && !hit)
		|=> tmr_count != $past(tmr_count))
		else $error("live value did not move");
	// Halt holds the count
	halt_hold_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(!tmr_en && !tmr_load && !hit) |=> $stable(cnt_q))
		else $error("halted counter moved");
	// Enabled match raises the level
	alarm_level_a: assert property (
		@(posedge core_clk) disable iff (rst)
		hit |=> tmr_int)
		else $error("alarm interrupt missing");
	// Level stays until cleared
	int_sticky_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(tmr_int && !tmr_int_clr) |=> tmr_int)
		else $error("interrupt dropped early");
	// Clear without a match drops the level
	int_clear_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(tmr_int_clr && !hit) |=> !tmr_int)
		else $error("interrupt not cleared");
	// No match keeps a low level low
	alarm_quiet_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(!hit && !tmr_int) |=> !tmr_int)
		else $error("interrupt raised without match");
	// Locked configuration holds
	cfg_locked_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(lock_q && !wdt_key_wr)
		|=> $stable(tmo_q) && $stable(en_q))
		else $error("locked config changed");
	// Right key removes the protection
	key_unlock_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(wdt_key_wr && wdt_key == TGW_WDT_KEY)
		|=> !wdt_locked)
		else $error("key did not unlock");
	// Any other key restores the protection
	key_relock_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(wdt_key_wr && wdt_key != TGW_WDT_KEY)
		|=> wdt_locked)
		else $error("wrong key did not lock");
	// Interrupt action reaches its output
	int_route_a: assert property (
		@(posedge core_clk) disable iff (rst)
		wif.intr |=> wdt_int)
		else $error("stage interrupt lost");
	// Core reset action reaches its output
	core_route_a: assert property (
		@(posedge core_clk) disable iff (rst)
		wif.core_rst |=> core_rst_out)
		else $error("core reset lost");
	// Overdue boot resets the system
	boot_guard_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(boot_q && !boot_done && bcnt_q >= BOOT_TMO)
		|=> sys_rst_out)
		else $error("boot guard reset missing");
	// Finished boot stops the guard quietly
	boot_done_a: assert property (
		@(posedge core_clk) disable iff (rst)
		(boot_q && boot_done)
		|=> (!boot_q && !sys_rst_out))
		else $error("boot guard ran past boot");
	// Idle guard never resets
	boot_quiet_a: assert property (
		@(posedge core_clk) disable iff (rst)
		!boot_q |=> !sys_rst_out)
		else $error("system reset without boot guard");
	cover_alarm: cover property (@(posedge core_clk) hit && tmr_reload_en);
	cover_unlock: cover property (@(posedge core_clk) $fell(lock_q));
	cover_boot: cover property (@(posedge core_clk) sys_rst_out);
endmodule // tgw_top

// ### tb_tgw_top.sv
//==============================================================
// Purpose: Self-checking bench for the timer group block
// Assumes: Group zero instance with a shortened boot guard
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/1ps
module tb_tgw_top;
	import tgw_pkg::*;
	localparam logic [31:0] BOOT_CYC = 32'h0000_0032; // 50 cycles
	logic         core_clk      = 1'b0;
	logic         rst           = 1'b1;
	logic         tmr_en        = 1'b0;
	logic         tmr_up        = 1'b1;
	logic         tmr_reload_en = 1'b0;
	logic [15:0]  tmr_div       = 16'h0;
	logic [53:0]  tmr_reload    = 54'h0;
	logic         tmr_load      = 1'b0;
	logic [53:0]  tmr_alarm     = 54'h0;
	logic         tmr_alarm_en  = 1'b0;
	logic         tmr_int_clr   = 1'b0;
	logic [53:0]  tmr_count;
	logic         tmr_int;
	logic [31:0]  wdt_key       = 32'h0;
	logic         wdt_key_wr    = 1'b0;
	logic         wdt_cfg_wr    = 1'b0;
	logic         wdt_en_in     = 1'b0;
	logic [3:0]   wdt_stage_en  = 4'h0;
	logic [127:0] wdt_tmo       = 128'h0;
	logic [7:0]   wdt_act       = 8'h0;
	logic         wdt_feed      = 1'b0;
	logic         boot_done     = 1'b0;
	logic         wdt_locked, wdt_int, cpu_rst_out, core_rst_out;
	logic         sys_rst_out;
	int           bad_count = 0;
	int           compares  = 0;
	int           cyc       = 0;
	int           n_int, n_cpu, n_core, n_sys, t_int, t_cpu, t_core;
	logic [53:0]  c0;

	//==========================================================
	// Device under test
	tgw_top #(.GROUP_ID(0), .BOOT_TMO(BOOT_CYC)) u_tgw_top (
		.core_clk, .rst, .tmr_en, .tmr_up, .tmr_reload_en, .tmr_div,
		.tmr_reload, .tmr_load, .tmr_alarm, .tmr_alarm_en,
		.tmr_int_clr, .tmr_count, .tmr_int, .wdt_key, .wdt_key_wr,
		.wdt_cfg_wr, .wdt_en_in, .wdt_stage_en, .wdt_tmo, .wdt_act,
		.wdt_feed, .boot_done, .wdt_locked, .wdt_int, .cpu_rst_out,
		.core_rst_out, .sys_rst_out
	);

	// Clock, 50 ns period
	always #25 core_clk = ~core_clk;

	// Event counters and hang guard
	always @(posedge core_clk)
	begin
		cyc = cyc + 1;
		if (wdt_int === 1'b1 && n_int == 0) t_int = cyc;
		if (cpu_rst_out === 1'b1 && n_cpu == 0) t_cpu = cyc;
		if (core_rst_out === 1'b1 && n_core == 0) t_core = cyc;
		if (wdt_int === 1'b1) n_int++;
		if (cpu_rst_out === 1'b1) n_cpu++;
		if (core_rst_out === 1'b1) n_core++;
		if (sys_rst_out === 1'b1) n_sys++;
		if (cyc == 5000)
		begin
			bad_count++;
			end_sim();
		end
	end

	//==========================================================
	// Helper tasks
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic clr_ev();
		n_int = 0;
		n_cpu = 0;
		n_core = 0;
		n_sys = 0;
	endtask

	task automatic do_reset(input logic bd);
		rst = 1'b1;
		boot_done = bd;
		tick(8);
		rst = 1'b0;
	endtask

	task automatic key_wr(input logic [31:0] k);
		wdt_key = k;
		wdt_key_wr = 1'b1;
		tick(1);
		wdt_key_wr = 1'b0;
		tick(1);
	endtask

	task automatic cfg_wr(input logic [3:0] se, input logic [7:0] act);
		wdt_en_in = 1'b1;
		wdt_stage_en = se;
		wdt_act = act;
		wdt_cfg_wr = 1'b1;
		tick(1);
		wdt_cfg_wr = 1'b0;
	endtask

	task automatic pulse_feed();
		wdt_feed = 1'b1;
		tick(1);
		wdt_feed = 1'b0;
	endtask

	//==========================================================
	// Main sequence
	initial
	begin
		do_reset(1'b0);
		check("count_rst", tmr_count, 54'h0);
		check("int_rst", tmr_int, 1'b0);
		check("locked_rst", wdt_locked, 1'b1);
		clr_ev();
		tick(45);
		check("sys_early", n_sys, 0);
		tick(25);
		check("sys_fired", n_sys > 0, 1'b1);
		check("boot_wdt", n_core > 0, 1'b1);
		do_reset(1'b1);
		clr_ev();
		tick(80);
		check("sys_quiet", n_sys, 0);
		$display("test boot guard done");
		// Timer up count, prescale ratios, halt and down count
		tmr_en = 1'b1;
		tick(10);
		check("count_up", tmr_count, 54'hA);
		for (int d = 0; d < 4; d++)
		begin
			tmr_div = 16'((1 << d) - 1);
			tick(4);
			c0 = tmr_count;
			tick(40);
			check("prescale", tmr_count - c0, 54'(40 >> d));
		end
		tmr_div = 16'h0;
		tmr_en = 1'b0;
		tick(1);
		c0 = tmr_count;
		tick(20);
		check("halted", tmr_count, c0);
		tmr_en = 1'b1;
		tick(5);
		check("resumed", tmr_count, c0 + 54'h5);
		tmr_reload = 54'h3;
		tmr_load = 1'b1;
		tmr_up = 1'b0;
		tick(1);
		tmr_load = 1'b0;
		tick(5);
		check("count_down", tmr_count, 54'h3F_FFFF_FFFF_FFFE);
		$display("test timer count done");
		// Alarm with reload, sticky level, clear, disabled alarm
		tmr_up = 1'b1;
		tmr_reload = 54'h0;
		tmr_load = 1'b1;
		tick(1);
		tmr_load = 1'b0;
		tmr_reload = 54'h20;
		tmr_alarm = 54'h8;
		tmr_alarm_en = 1'b1;
		tmr_reload_en = 1'b1;
		for (int i = 0; i < 20 && tmr_int !== 1'b1; i++) tick(1);
		check("reloaded", tmr_count, 54'h20);
		tick(5);
		check("int_held", tmr_int, 1'b1);
		check("after_reload", tmr_count, 54'h25);
		tmr_int_clr = 1'b1;
		tick(1);
		tmr_int_clr = 1'b0;
		check("int_clr", tmr_int, 1'b0);
		tmr_alarm_en = 1'b0;
		tmr_reload = 54'h0;
		tmr_load = 1'b1;
		tick(1);
		tmr_load = 1'b0;
		tick(20);
		check("alarm_off", tmr_int, 1'b0);
		$display("test timer alarm done");
		// Unlock, stage sequence with one stage disabled
		key_wr(32'h1234_5678);
		check("bad_key", wdt_locked, 1'b1);
		key_wr(TGW_WDT_KEY);
		check("unlocked", wdt_locked, 1'b0);
		wdt_tmo = {4{32'h0000_000A}};
		cfg_wr(4'b1011, 8'hE9);
		pulse_feed();
		tick(3);
		clr_ev();
		tick(80);
		check("stage_int", n_int, 1);
		check("stage_cpu", n_cpu, 1);
		check("stage_skip", n_core, 1);
		check("stage_order", t_int < t_cpu && t_cpu < t_core, 1'b1);
		$display("test watchdog stages done");
		// Feeding holds off expiry; locked feeds are ignored
		wdt_tmo = {4{32'h0000_0014}};
		cfg_wr(4'b0001, 8'h01);
		pulse_feed();
		tick(3);
		clr_ev();
		repeat (6)
		begin
			tick(9);
			pulse_feed();
		end
		check("fed", n_int, 0);
		tick(30);
		check("starved", n_int, 1);
		pulse_feed();
		key_wr(32'h0);
		clr_ev();
		repeat (4)
		begin
			tick(4);
			pulse_feed();
		end
		tick(10);
		check("locked_feed", n_int, 1);
		$display("test watchdog feed done");
		end_sim();
	end
endmodule // tb_tgw_top
